// File: hdl/sctr_consts.vh
// What this block does
// (RULE_01) Soft settle field picks 0-310 us, 10 us steps.
// (RULE_02) Soft settle field resets to 100 us.
// (RULE_03) Post-cal settle field picks 0-70 us.
// (RULE_04) Post-cal settle field resets to 20 us.
// (RULE_05) Cold start settle is soft plus post-cal.
// (RULE_06) Bad preamble window is threshold times four bits.
// (RULE_07) Wake-halving bit halves crystal wake time.
// (RULE_08) Converter calibration done reads back as one.
// (RULE_09) Fine enable repeats RC calibration every 30 s.
// (RULE_10) Force bit rising starts 2 ms RC calibration.
// (RULE_11) Wake timer or wake-on-receive starts RC calibration.
// (RULE_12) Host keeps RC oscillator on during calibration.
// (RULE_13) Double precision lengthens VCO calibration measurement.
// (RULE_14) VCO force in idle with PLL on calibrates once.
// (RULE_15) Skip bit omits VCO calibration idle to receive.
// (RULE_16) Bypass bits disable recovery and slicer compensation.
// (RULE_17) Dither type selects plus-one-or-zero or plus-minus-one.
// (RULE_18) Oscillation detection runs while disable bit low.
// (RULE_19) OOK threshold uses eight or four preamble bits.
// (RULE_20) Reference select picks 10 MHz or PLL; inversion.
// (RULE_21) Clearing toggle bit stops discriminator toggling.
// (RULE_22) Pump current field and force up/down/offset bits.
// (RULE_23) Correction reads pump value, or override value.
// (RULE_24) Written correction value wakes up as zeros.
`ifndef SCTR_CONSTS_VH
`define SCTR_CONSTS_VH

// Register addresses on the serial port.
`define SCTR_ADDR_SETTLE 7'h53
`define SCTR_ADDR_PREAMBLE 7'h54
`define SCTR_ADDR_CAL 7'h55
`define SCTR_ADDR_MODEM 7'h56
`define SCTR_ADDR_PUMP 7'h57
`define SCTR_ADDR_CORR 7'h58

// Reset values.
`define SCTR_RST_SETTLE 8'h52
`define SCTR_RST_PREAMBLE 8'h54
`define SCTR_RST_CAL 8'h44
`define SCTR_RST_MODEM 8'h00
`define SCTR_RST_PUMP 8'h00
`define SCTR_RST_CORR 8'h80

// Field positions in the calibration control register.
`define SCTR_CAL_XTAL_HALF 6
`define SCTR_CAL_ADC_DONE 5
`define SCTR_CAL_FINE_EN 4
`define SCTR_CAL_RC_FORCE 3
`define SCTR_CAL_VCO_DP 2
`define SCTR_CAL_VCO_FORCE 1
`define SCTR_CAL_SKIP_VCO 0

// Field positions in the correction register.
`define SCTR_CORR_OVERRIDE 5

// Timing.
`define SCTR_CLK_MHZ 250
`define SCTR_SETTLE_STEP_US 10
`define SCTR_SETTLE_STEP_CYCLES (`SCTR_SETTLE_STEP_US * `SCTR_CLK_MHZ)
`define SCTR_RC_CAL_TIME_US 2000
`define SCTR_RC_CAL_CYCLES (`SCTR_RC_CAL_TIME_US * `SCTR_CLK_MHZ)
`define SCTR_FINE_CAL_TIME_S 30
`define SCTR_FINE_CAL_CYCLES (`SCTR_FINE_CAL_TIME_S * 36'd1000000 * `SCTR_CLK_MHZ)
`define SCTR_PREAMBLE_SCALE 4

`endif

// File: hdl/sctr_regs.v
`timescale 1ns/1ps
`include "sctr_consts.vh"

module sctr_regs #(
  // Length of one RC calibration run in clock cycles.
  parameter [18:0] RC_CAL_CYCLES = `SCTR_RC_CAL_CYCLES,
  // Period of the repeating fine calibration in clock cycles.
  parameter [35:0] FINE_CAL_CYCLES = `SCTR_FINE_CAL_CYCLES
) (
  // Clock, reset and freeze.
  input wire clock,
  input wire reset_n,
  input wire clockEnable,
  // Serial register port pins.
  input wire spiSelect_n,
  input wire spiClock,
  input wire spiDataIn,
  output wire spiDataOut,
  output wire spiDataOutEn,
  // Chip state from the same clock domain.
  input wire modeIdle,
  input wire pllOn,
  input wire idleToRx,
  input wire wakeTimerEn,
  input wire wakeOnRx,
  input wire rcOscOn,
  input wire adcCalDone,
  input wire vcoCalDone,
  input wire [4:0] pumpCorrSeen,
  // Synthesizer timing.
  output reg [16:0] softSettleCycles,
  output reg [16:0] postCalSettleCycles,
  output reg [16:0] coldSettleCycles,
  output reg [5:0] badPreambleWindowBits,
  output wire amp_regulator_boost,
  output wire amp_bias_boost,
  output wire xtalWakeHalf,
  // Calibration control.
  output reg rcCalBusy,
  output reg rcCalStart,
  output reg vcoCalStart,
  output wire vcoCalDoublePrecision,
  // Demodulator test options.
  output wire clockRecoveryBypass,
  output wire slicerBypass,
  output wire ditherPlusMinus,
  output wire oscDetectEnable,
  output wire ookThresholdEightBits,
  output wire refClockIs10MHz,
  output wire refClockInvert,
  output wire discToggleEnable,
  // Charge pump controls.
  output wire pumpDirect7,
  output wire pumpDirect6,
  output wire pumpForceUp,
  output wire pumpForceDown,
  output wire pumpOffsetOnly,
  output wire [2:0] pumpDcCurrent,
  output wire [1:0] pumpGain,
  output wire pumpCorrOverride,
  output reg [4:0] pumpCorrDrive
);

  // Stored register bytes.
  reg [7:0] settleReg;
  reg [7:0] preambleReg;
  reg [7:0] modemReg;
  reg [7:0] pumpReg;
  reg [7:0] corrReg;
  // Stored calibration control bits.
  reg xtalHalf;
  reg fineCalEn;
  reg vcoCalDp;
  // Busy flag of the forced VCO run; it reads back as the force bit.
  reg vcoCalBusy;
  reg skipVco;

  // Pin synchronisers: two flops, plus a history flop for edges.
  reg selMeta;
  reg selSync;
  reg sclkMeta;
  reg sclkSync;
  reg sclkPrev;
  reg dinMeta;
  reg dinSync;

  // Serial framing state.
  // Bit position inside the current byte.
  reg [2:0] bitCount;
  // The command byte of this frame has been taken.
  reg haveCmd;
  // The frame is a write frame.
  reg isWrite;
  // Register address, stepped by one after each data byte.
  reg [6:0] addr;
  // The first seven bits of the byte being shifted in.
  reg [6:0] shiftIn;
  // The byte being shifted out, most significant bit first.
  reg [7:0] shiftOut;
  // Read data is to be loaded at the next falling serial clock.
  reg loadOut;

  // RC calibration timers.
  // Cycles of the running RC calibration, counted only while the oscillator runs.
  reg [18:0] rcCount;
  // Cycles towards the next periodic fine calibration.
  reg [35:0] fineCount;
  // Last level of the wake request, for edge detection.
  reg autoPrev;

  // Decoded serial events.
  // Select is active low; a frame lives only while it stays low.
  wire csActive = ~selSync;
  wire sclkRise = sclkSync & ~sclkPrev;
  wire sclkFall = ~sclkSync & sclkPrev;
  wire [7:0] byteNow = {shiftIn, dinSync};
  wire byteEnd = csActive & sclkRise & (bitCount == 3'h7);
  wire wrFire = clockEnable & byteEnd & haveCmd & isWrite;

  // Write decode per register.
  // Writes to unmapped addresses match none of these and are dropped.
  wire wrSettle = wrFire & (addr == `SCTR_ADDR_SETTLE);
  wire wrPreamble = wrFire & (addr == `SCTR_ADDR_PREAMBLE);
  wire wrCal = wrFire & (addr == `SCTR_ADDR_CAL);
  wire wrModem = wrFire & (addr == `SCTR_ADDR_MODEM);
  wire wrPump = wrFire & (addr == `SCTR_ADDR_PUMP);
  wire wrCorr = wrFire & (addr == `SCTR_ADDR_CORR);

  // Calibration triggers.
  // A rise of the combined wake level (one source rising while the other is low) starts one run, even while another is running.
  wire autoLevel = wakeTimerEn | wakeOnRx;
  wire autoRise = autoLevel & ~autoPrev;
  wire fineDue = fineCalEn & (fineCount == FINE_CAL_CYCLES - 36'h1);
  wire forceRise = wrCal & byteNow[`SCTR_CAL_RC_FORCE] & ~rcCalBusy;
  wire rcKick = forceRise | autoRise | fineDue;
  wire rcDone = rcCalBusy & rcOscOn & (rcCount == RC_CAL_CYCLES - 19'h1);
  wire vcoAllowed = modeIdle & pllOn;
  wire vcoKick = wrCal & byteNow[`SCTR_CAL_VCO_FORCE] & vcoAllowed;
  wire vcoOnRx = idleToRx & ~skipVco;

  // Correction readback is the pump's own value unless overridden.
  wire [4:0] corrSeen = corrReg[`SCTR_CORR_OVERRIDE] ? corrReg[4:0] : pumpCorrSeen; // RULE_23

  // Settling and window products, kept at full width and cut on purpose where they are stored.
  // The largest soft product is 77500 cycles and the largest sum 95000, so 17 bits hold them.
  wire [31:0] softProduct = settleReg[7:3] * `SCTR_SETTLE_STEP_CYCLES;
  wire [31:0] postProduct = settleReg[2:0] * `SCTR_SETTLE_STEP_CYCLES;
  wire [31:0] coldProduct = softProduct + postProduct;
  // The window never exceeds 60 bit periods, which fits in six bits.
  wire [31:0] windowProduct = preambleReg[5:2] * `SCTR_PREAMBLE_SCALE;

  // Read data for the current address; unmapped reads give zero.
  reg [7:0] readData;

  // Read multiplexer.
  always @* begin
    case (addr)
      `SCTR_ADDR_SETTLE: readData = settleReg;
      `SCTR_ADDR_PREAMBLE: readData = preambleReg;
      // Bit 7 is reserved and reads zero.
      `SCTR_ADDR_CAL: readData = {1'b0, xtalHalf, adcCalDone, fineCalEn, rcCalBusy, vcoCalDp, vcoCalBusy, skipVco}; // RULE_08
      `SCTR_ADDR_MODEM: readData = modemReg;
      `SCTR_ADDR_PUMP: readData = pumpReg;
      // The correction field shows what the pump sees unless the override is set.
      `SCTR_ADDR_CORR: readData = {corrReg[7:5], corrSeen}; // RULE_23
      default: readData = 8'h00;
    endcase
  end

  // Pin synchronisers; the first stage feeds only the second.
  // Select resets high and the serial clock low, their idle levels, so no false edge follows reset.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      selMeta <= 1'b1;
      selSync <= 1'b1;
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkPrev <= 1'b0;
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
    end else if (clockEnable) begin
      selMeta <= spiSelect_n;
      selSync <= selMeta;
      sclkMeta <= spiClock;
      sclkSync <= sclkMeta;
      sclkPrev <= sclkSync;
      dinMeta <= spiDataIn;
      dinSync <= dinMeta;
    end
  end

  // Serial framing: command byte, then data bytes with address increment.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bitCount <= 3'h0;
      haveCmd <= 1'b0;
      isWrite <= 1'b0;
      addr <= 7'h00;
      shiftIn <= 7'h00;
      shiftOut <= 8'h00;
      loadOut <= 1'b0;
    end else if (clockEnable) begin
      if (!csActive) begin
        // Deselect ends the frame.
        // A partial byte is dropped; the direction and address are renewed by the next command.
        bitCount <= 3'h0;
        haveCmd <= 1'b0;
        loadOut <= 1'b0;
      end else begin
        if (sclkRise) begin
          shiftIn <= byteNow[6:0];
          bitCount <= bitCount + 3'h1;
          if (bitCount == 3'h7) begin
            if (!haveCmd) begin
              // Top bit high marks a write.
              haveCmd <= 1'b1;
              isWrite <= byteNow[7];
              addr <= byteNow[6:0];
              loadOut <= ~byteNow[7];
            end else begin
              addr <= addr + 7'h01;
              loadOut <= ~isWrite;
            end
          end
        end
        // Read data changes on the falling serial clock edge.
        if (sclkFall) begin
          if (loadOut) begin
            shiftOut <= readData;
            loadOut <= 1'b0;
          end else begin
            shiftOut <= {shiftOut[6:0], 1'b0};
          end
        end
      end
    end
  end

  // The data pin is driven only in a read frame after its command byte.
  assign spiDataOut = shiftOut[7];
  assign spiDataOutEn = csActive & haveCmd & ~isWrite;

  // Plain read/write registers.
  // A write lands at the clock that sees the eighth rise of its data byte.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settleReg <= `SCTR_RST_SETTLE; // RULE_02 RULE_04
      preambleReg <= `SCTR_RST_PREAMBLE;
      modemReg <= `SCTR_RST_MODEM;
      pumpReg <= `SCTR_RST_PUMP;
      corrReg <= `SCTR_RST_CORR; // RULE_24
      // The reset byte has the wake-halving and double-precision bits set.
      xtalHalf <= 1'b1;
      fineCalEn <= 1'b0;
      vcoCalDp <= 1'b1;
      skipVco <= 1'b0;
    end else if (clockEnable) begin
      if (wrSettle) begin
        settleReg <= byteNow;
      end
      if (wrPreamble) begin
        preambleReg <= byteNow;
      end
      if (wrModem) begin
        modemReg <= byteNow;
      end
      if (wrPump) begin
        pumpReg <= byteNow;
      end
      if (wrCorr) begin
        corrReg <= byteNow;
      end
      if (wrCal) begin
        xtalHalf <= byteNow[`SCTR_CAL_XTAL_HALF];
        fineCalEn <= byteNow[`SCTR_CAL_FINE_EN];
        vcoCalDp <= byteNow[`SCTR_CAL_VCO_DP];
        skipVco <= byteNow[`SCTR_CAL_SKIP_VCO];
      end
    end
  end

  // RC calibration: forced, automatic or periodic; self-clearing busy bit.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rcCalBusy <= 1'b0;
      rcCalStart <= 1'b0;
      rcCount <= 19'h0;
      fineCount <= 36'h0;
      autoPrev <= 1'b0;
    end else if (clockEnable) begin
      autoPrev <= autoLevel;
      rcCalStart <= rcKick; // RULE_10 RULE_11
      // Periodic fine calibration timer runs only while enabled.
      // The count restarts at every expiry, so starts come at a fixed period.
      if (!fineCalEn || fineDue) begin
        fineCount <= 36'h0;
      end else begin
        fineCount <= fineCount + 36'h1; // RULE_09
      end
      // A force write while busy never reaches rcKick, so a running calibration is not restarted by it.
      if (rcKick) begin
        // A new start wins over a finishing run.
        rcCalBusy <= 1'b1; // RULE_10
        rcCount <= 19'h0;
      end else if (rcDone) begin
        rcCalBusy <= 1'b0; // RULE_10
      end else if (rcCalBusy && rcOscOn) begin
        // The run only advances while the oscillator runs.
        rcCount <= rcCount + 19'h1; // RULE_12
      end
    end
  end

  // VCO calibration: one-shot force in idle with PLL on, and on receive entry.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vcoCalBusy <= 1'b0;
      vcoCalStart <= 1'b0;
    end else if (clockEnable) begin
      vcoCalStart <= vcoKick | vcoOnRx; // RULE_14 RULE_15
      // The force bit reads one until the synthesizer reports the run finished.
      // Entry into receive only pulses the start and leaves the force bit alone.
      if (vcoKick) begin
        vcoCalBusy <= 1'b1; // RULE_14
      end else if (vcoCalDone) begin
        vcoCalBusy <= 1'b0; // RULE_14
      end
    end
  end

  // Timing outputs derived from the register fields, and the pump correction drive from corrSeen.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      softSettleCycles <= 17'h0;
      postCalSettleCycles <= 17'h0;
      coldSettleCycles <= 17'h0;
      badPreambleWindowBits <= 6'h0;
      pumpCorrDrive <= 5'h0;
    end else if (clockEnable) begin
      softSettleCycles <= softProduct[16:0]; // RULE_01
      postCalSettleCycles <= postProduct[16:0]; // RULE_03
      coldSettleCycles <= coldProduct[16:0]; // RULE_05
      badPreambleWindowBits <= windowProduct[5:0]; // RULE_06
      pumpCorrDrive <= corrSeen; // RULE_23
    end
  end

  // Static controls taken from the register bits; only the oscillation detector enable is inverted.
  assign amp_regulator_boost = preambleReg[1];
  assign amp_bias_boost = preambleReg[0];
  assign xtalWakeHalf = xtalHalf; // RULE_07
  assign vcoCalDoublePrecision = vcoCalDp; // RULE_13
  assign clockRecoveryBypass = modemReg[7]; // RULE_16
  assign slicerBypass = modemReg[6]; // RULE_16
  assign ditherPlusMinus = modemReg[5]; // RULE_17
  // The oscillation detector runs while its disable bit is low.
  assign oscDetectEnable = ~modemReg[4]; // RULE_18
  assign ookThresholdEightBits = modemReg[3]; // RULE_19
  assign refClockIs10MHz = modemReg[2]; // RULE_20
  assign refClockInvert = modemReg[1]; // RULE_20
  assign discToggleEnable = modemReg[0]; // RULE_21
  // Bits 7 and 6 of the pump test register go straight to the analog side.
  assign pumpDirect7 = pumpReg[7];
  assign pumpDirect6 = pumpReg[6];
  assign pumpForceUp = pumpReg[5]; // RULE_22
  assign pumpForceDown = pumpReg[4]; // RULE_22
  assign pumpOffsetOnly = pumpReg[3]; // RULE_22
  assign pumpDcCurrent = pumpReg[2:0]; // RULE_22
  assign pumpGain = corrReg[7:6];
  assign pumpCorrOverride = corrReg[`SCTR_CORR_OVERRIDE]; // RULE_23

endmodule // sctr_regs

// File: verif/sctr_host.sv
`timescale 1ns/1ps
module sctr_host (
  // Serial pins toward the register bank.
  input wire clock,
  output logic spiSelect_n,
  output logic spiClock,
  output logic spiDataIn,
  input wire spiDataOut
);
  // The port idles deselected with its clock low.
  initial begin
    spiSelect_n = 1'b1;
    spiClock = 1'b0;
    spiDataIn = 1'b0;
  end
  // One byte goes MSB first. Each clock phase lasts eight clocks so the bank's synchroniser keeps up.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spiDataIn = tx[i];
      repeat (8) @(posedge clock);
      #1 spiClock = 1'b1;
      rx[i] = spiDataOut;
      repeat (8) @(posedge clock);
      #1 spiClock = 1'b0;
    end
  endtask
  // A frame is a command byte and then one data byte.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    spiSelect_n = 1'b0;
    xfer(cmd, junk);
    xfer(wd, rd);
    repeat (8) @(posedge clock);
    #1 spiSelect_n = 1'b1;
    // A released data line must not keep a value that looks valid.
    spiDataIn = ~spiDataIn;
    repeat (8) @(posedge clock);
    #1;
  endtask
endmodule // sctr_host

// File: verif/sctr_regs_chk.sv
`timescale 1ns/1ps
module sctr_regs_chk #(
  parameter [18:0] RC_CAL_CYCLES = 19'd20
) (
  // Clock, reset and inputs.
  input wire clock,
  input wire reset_n,
  input wire clockEnable,
  input wire rcOscOn,
  input wire wakeTimerEn,
  input wire wakeOnRx,
  input wire [4:0] pumpCorrSeen,
  // Outputs under watch.
  input wire [16:0] softSettleCycles,
  input wire [16:0] postCalSettleCycles,
  input wire [16:0] coldSettleCycles,
  input wire [5:0] badPreambleWindowBits,
  input wire rcCalBusy,
  input wire rcCalStart,
  input wire vcoCalStart,
  input wire pumpCorrOverride,
  input wire [4:0] pumpCorrDrive
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Counts the running edges of an RC calibration.
  logic [19:0] busyCount;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busyCount <= 20'h00000;
    end else if (!rcCalBusy) begin
      busyCount <= 20'h00000;
    end else if (rcOscOn && clockEnable) begin
      busyCount <= busyCount + 20'h00001;
    end
  end
  chk_cold_sum:
  assert property ($stable(softSettleCycles) && $stable(postCalSettleCycles) |->
    coldSettleCycles == softSettleCycles + postCalSettleCycles) else $error("cold settle is not the sum");
  chk_settle_grid:
  assert property (softSettleCycles % 2500 == 0 && softSettleCycles <= 77500) else $error("soft settle off grid");
  chk_post_grid:
  assert property (postCalSettleCycles % 2500 == 0 && postCalSettleCycles <= 17500) else $error("post settle off grid");
  chk_window_mult:
  assert property (badPreambleWindowBits[1:0] == 2'b00) else $error("window not a multiple of four");
  chk_rc_pulse:
  assert property (rcCalStart |=> !rcCalStart) else $error("RC start longer than one cycle");
  chk_busy_start:
  assert property ($rose(rcCalBusy) |-> rcCalStart) else $error("busy without start");
  chk_rc_length:
  assert property ($fell(rcCalBusy) |-> busyCount + 20'd2 >= RC_CAL_CYCLES && busyCount <= RC_CAL_CYCLES + 1)
    else $error("RC calibration length wrong");
  chk_wake_start:
  assert property ($rose(wakeTimerEn || wakeOnRx) && !rcCalBusy |=> rcCalStart) else $error("wake gave no RC start");
  chk_vco_pulse:
  assert property (vcoCalStart |=> !vcoCalStart) else $error("VCO start longer than one cycle");
  chk_corr_follow:
  assert property ($past(reset_n) && $past(clockEnable) && $past(!pumpCorrOverride) && !pumpCorrOverride |->
    pumpCorrDrive == $past(pumpCorrSeen)) else $error("pump drive does not follow pump");
  // Main scenarios.
  cover property (rcCalStart);
  cover property (vcoCalStart);
  cover property ($fell(rcCalBusy));
endmodule // sctr_regs_chk
bind sctr_regs sctr_regs_chk #(.RC_CAL_CYCLES(RC_CAL_CYCLES)) u_chk (.*);

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Inputs; rcOscOn and adcCalDone stay constant, clockEnable drops once.
  logic clock = 0, reset_n = 0, clockEnable = 1, modeIdle = 0, pllOn = 0, idleToRx = 0;
  logic wakeTimerEn = 0, wakeOnRx = 0, rcOscOn = 1, adcCalDone = 1, vcoCalDone = 0;
  logic [4:0] pumpCorrSeen = 5'h0A;
  logic spiSelect_n, spiClock, spiDataIn;
  // Outputs.
  wire spiDataOut, spiDataOutEn, amp_regulator_boost, amp_bias_boost, xtalWakeHalf, rcCalBusy, rcCalStart;
  wire vcoCalStart, vcoCalDoublePrecision, clockRecoveryBypass, slicerBypass, ditherPlusMinus, oscDetectEnable;
  wire ookThresholdEightBits, refClockIs10MHz, refClockInvert, discToggleEnable, pumpDirect7, pumpDirect6;
  wire pumpForceUp, pumpForceDown, pumpOffsetOnly, pumpCorrOverride;
  wire [16:0] softSettleCycles, postCalSettleCycles, coldSettleCycles;
  wire [5:0] badPreambleWindowBits;
  wire [4:0] pumpCorrDrive;
  wire [2:0] pumpDcCurrent;
  wire [1:0] pumpGain;
  int err_count = 0, n_tests = 0, rcStarts = 0, vcoStarts = 0, cycles = 0, oeSeen = 0;
  logic [7:0] r, v;
  logic [7:0] rstVal [6] = '{8'h52, 8'h54, 8'h64, 8'h00, 8'h00, 8'h8A};
  sctr_regs #(.RC_CAL_CYCLES(19'd1000), .FINE_CAL_CYCLES(36'd3000)) dut (.*);
  sctr_host host (.clock(clock), .spiSelect_n(spiSelect_n), .spiClock(spiClock), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut));
  always #2 clock = ~clock;
  // Counts start pulses and cuts a hang short.
  always @(posedge clock) begin
    rcStarts += (rcCalStart === 1'b1);
    vcoStarts += (vcoCalStart === 1'b1);
    oeSeen += (spiDataOutEn === 1'b1);
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.frame({1'b1, a}, d, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.frame({1'b0, a}, 8'h00, d);
  endtask
  // Registers first, then the calibration triggers.
  initial begin
    step(10);
    reset_n = 1;
    step(5);
    chk({softSettleCycles, postCalSettleCycles}, {17'd25000, 17'd5000});
    chk({coldSettleCycles, badPreambleWindowBits}, {17'd30000, 6'd20});
    for (int i = 0; i < 6; i++) begin
      rd(7'(8'h53 + i), r);
      chk(r, rstVal[i]);
    end
    chk({spiDataOutEn, oeSeen > 0}, 2'b01);
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h00 : 8'hFF;
      wr(7'h53, v);
      chk(softSettleCycles, v[7:3] * 2500);
      chk(postCalSettleCycles, v[2:0] * 2500);
      chk(coldSettleCycles, (v[7:3] + v[2:0]) * 2500);
      v = i ? 8'h5A : 8'hA5;
      wr(7'h56, v);
      rd(7'h56, r);
      chk({r, clockRecoveryBypass, slicerBypass, ditherPlusMinus, ~oscDetectEnable, ookThresholdEightBits,
        refClockIs10MHz, refClockInvert, discToggleEnable}, {v, v});
    end
    wr(7'h54, 8'hBE);
    rd(7'h54, r);
    chk({r, badPreambleWindowBits, amp_regulator_boost, amp_bias_boost}, {8'hBE, 6'd60, 2'b10});
    wr(7'h57, 8'hC9);
    rd(7'h57, r);
    chk({r, pumpDirect7, pumpDirect6, pumpForceUp, pumpForceDown, pumpOffsetOnly, pumpDcCurrent}, 16'hC9C9);
    wr(7'h58, 8'h73);
    rd(7'h58, r);
    chk({r, pumpGain, pumpCorrOverride, pumpCorrDrive}, {8'h73, 2'b01, 1'b1, 5'h13});
    wr(7'h58, 8'h80);
    pumpCorrSeen = 5'h15;
    rd(7'h58, r);
    chk({r, pumpCorrDrive}, {8'h95, 5'h15});
    clockEnable = 0;
    pumpCorrSeen = 5'h0C;
    step(3);
    chk(pumpCorrDrive, 5'h15);
    clockEnable = 1;
    step(2);
    chk(pumpCorrDrive, 5'h0C);
    wr(7'h59, 8'hFF);
    rd(7'h59, r);
    rd(7'h53, v);
    chk({r, v}, 16'h0000);
    wr(7'h55, 8'h48);
    wr(7'h55, 8'h48);
    chk(rcStarts, 1);
    rd(7'h55, r);
    chk({r, xtalWakeHalf}, {8'h68, 1'b1});
    step(1100);
    rd(7'h55, r);
    chk({r, rcCalBusy}, {8'h60, 1'b0});
    wakeTimerEn = 1;
    step(5);
    chk(rcStarts, 2);
    step(1100);
    wakeTimerEn = 0;
    step(2);
    wakeOnRx = 1;
    step(5);
    chk(rcStarts, 3);
    step(1100);
    wr(7'h55, 8'h50);
    step(4000);
    chk(rcStarts, 4);
    wr(7'h55, 8'h40);
    step(1100);
    wr(7'h55, 8'h42);
    chk(vcoStarts, 0);
    modeIdle = 1;
    pllOn = 1;
    wr(7'h55, 8'h42);
    rd(7'h55, r);
    chk({r, vcoStarts[1:0]}, {8'h62, 2'd1});
    vcoCalDone = 1;
    step(1);
    vcoCalDone = 0;
    rd(7'h55, r);
    chk(r, 8'h60);
    for (int i = 0; i < 2; i++) begin
      wr(7'h55, i ? 8'h40 : 8'h45);
      idleToRx = 1;
      step(1);
      idleToRx = 0;
      step(3);
      chk({vcoCalDoublePrecision, vcoStarts[1:0]}, {i ? 1'b0 : 1'b1, 2'(1 + i)});
    end
    results();
  end
endmodule // tb_top
